// *** include/frr_defines.svh ***
// Offsets, field layout, reset values and counts of the reference readback bank
// Assumes inclusion by bare name from design and package files
`ifndef FRR_DEFINES_SVH
`define FRR_DEFINES_SVH

// --------------------------------------------------------------
// Register offsets (printed offsets, used directly as addresses)
// --------------------------------------------------------------
`define FRR_OFS_APPLIED_Q_VOLTAGE 12'h04e8
`define FRR_OFS_ALIGN_CURRENT_REFERENCE 12'h0524
`define FRR_OFS_OPEN_LOOP_SPEED_REFERENCE 12'h053c
`define FRR_OFS_OPEN_LOOP_CURRENT_REFERENCE 12'h054c
`define FRR_OFS_CLOSED_LOOP_SPEED_REFERENCE 12'h05d2
`define FRR_OFS_FLUX_CURRENT_REFERENCE 12'h0604

// --------------------------------------------------------------
// Field layout and reset values
// --------------------------------------------------------------
`define FRR_VALUE_MSB 31
`define FRR_VALUE_LSB 0
`define FRR_FRAC_BITS 27
`define FRR_RESET_VALUE 32'h0000_0000
`define FRR_UNMAPPED_VALUE 32'h0000_0000

// --------------------------------------------------------------
// Counts
// --------------------------------------------------------------
`define FRR_NUM_REGS 6
`define FRR_ADDR_W 12
`define FRR_DATA_W 32

`endif

// *** include/frr_pkg.sv ***
// Types of the reference readback bank
// Assumes frr_defines.svh is on the include path
`include "frr_defines.svh"

package frr_pkg;

	typedef logic [`FRR_DATA_W-1:0] frr_word_t;
	typedef logic [`FRR_ADDR_W-1:0] frr_addr_t;

	// Slot of each value in the bank storage
	typedef enum logic [2:0] {
		FRR_SLOT_APPLIED_Q_VOLTAGE = 3'h0,
		FRR_SLOT_ALIGN_CURRENT_REFERENCE = 3'h1,
		FRR_SLOT_OPEN_LOOP_SPEED_REFERENCE = 3'h2,
		FRR_SLOT_OPEN_LOOP_CURRENT_REFERENCE = 3'h3,
		FRR_SLOT_CLOSED_LOOP_SPEED_REFERENCE = 3'h4,
		FRR_SLOT_FLUX_CURRENT_REFERENCE = 3'h5
	} frr_slot_e;

endpackage : frr_pkg

// *** sim/frr_assertions.sv ***
// Port checker of the reference readback bank
// Assumes a bind onto the bank top, one clock
`timescale 1ns/1ps
module frr_checker (
	input wire logic ref_clk_i, input wire logic resetn_i, input wire logic [11:0] addr_i,
	input wire logic [31:0] wdata_i, input wire logic wr_i, input wire logic rd_i,
	input wire logic [31:0] rdata_o, input wire logic wr_dropped_o, input wire logic upd_valid_i,
	input wire logic [2:0] upd_slot_i, input wire logic [31:0] upd_data_i);
	wire mapped = addr_i inside {12'h04e8, 12'h0524, 12'h053c, 12'h054c, 12'h05d2, 12'h0604};
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	property p_rb(s, a);
		upd_valid_i && upd_slot_i == s ##1 rd_i && addr_i == a && !upd_valid_i
			|=> rdata_o == $past(upd_data_i, 2);
	endproperty
	a_volt_readback: assert property (p_rb(0, 12'h04e8)) else $error("bad read");
	a_align_readback: assert property (p_rb(1, 12'h0524)) else $error("bad read");
	a_olspd_readback: assert property (p_rb(2, 12'h053c)) else $error("bad read");
	a_olcur_readback: assert property (p_rb(3, 12'h054c)) else $error("bad read");
	a_clspd_readback: assert property (p_rb(4, 12'h05d2)) else $error("bad read");
	a_flux_readback: assert property (p_rb(5, 12'h0604)) else $error("bad read");
	a_unmapped_zero: assert property (rd_i && !mapped |=> rdata_o == 32'h0)
		else $error("bad read");
	a_write_dropped: assert property (wr_dropped_o == ($past(wr_i) && $past(mapped)))
		else $error("bad flag");
	cover property (wr_dropped_o);
	cover property (rd_i && !mapped);
	cover property (upd_valid_i && upd_slot_i > 3'h5);
endmodule : frr_checker

// *** sim/tb_top.sv ***
// Bench of the reference readback bank over the plain register port
// Assumes the design and checker are compiled first
`timescale 1ns/1ps
module tb_top;
	logic ref_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, upd_valid_i = 0, wr_dropped_o;
	logic [11:0] addr_i = 0;
	logic [2:0] upd_slot_i = 0;
	logic [31:0] wdata_i = 0, upd_data_i = 0, rdata_o, got;
	logic [11:0] ofs [6] = '{12'h04e8, 12'h0524, 12'h053c, 12'h054c, 12'h05d2, 12'h0604};
	logic [31:0] ev [6];
	int miscompares = 0, n_checks = 0;
	always #4 ref_clk_i = ~ref_clk_i;
	frr_reference_readback_regs u_frr_reference_readback_regs (.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .wr_dropped_o(wr_dropped_o), .upd_valid_i(upd_valid_i),
		.upd_slot_i(upd_slot_i), .upd_data_i(upd_data_i));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		upd_valid_i <= 1'b0;
		{wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
		@(posedge ref_clk_i);
		{wr_i, rd_i} <= 2'b00;
		#1 got = rdata_o;
		if (w)
			chk({31'h0, wr_dropped_o}, {31'h0, a inside {ofs}});
	endtask : bus
	task upd(input logic [2:0] s, input logic [31:0] d);
		@(posedge ref_clk_i);
		{upd_valid_i, upd_slot_i, upd_data_i} <= {1'b1, s, d};
	endtask : upd
	task rd_all;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ofs[i], 32'h0);
			chk(got, ev[i]);
			@(posedge ref_clk_i);
			#1 chk(rdata_o, 32'h0);
		end
	endtask : rd_all
	task do_reset;
		@(posedge ref_clk_i);
		resetn_i <= 1'b0;
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		ev = '{default: 32'h0};
		rd_all();
	endtask : do_reset
	task t_update;
		for (int i = 0; i < 6; i++) begin
			ev[i] = 32'h8000_0001 + 32'h0123_0000 * i;
			upd(3'(i), ev[i]);
			bus(1'b0, ofs[i], 32'h0);
			chk(got, ev[i]);
		end
	endtask : t_update
	task t_refused;
		for (int i = 0; i < 6; i++)
			bus(1'b1, ofs[i], ~ev[i]);
		bus(1'b1, 12'h0100, 32'hffff_ffff);
		bus(1'b0, 12'h0100, 32'h0);
		chk(got, 32'h0);
		upd(3'h6, 32'h1234_5678);
		upd(3'h7, 32'h1234_5678);
		rd_all();
	endtask : t_refused
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict
	initial begin
		do_reset();
		t_update();
		t_refused();
		do_reset();
		give_verdict();
	end
endmodule : tb_top
bind frr_reference_readback_regs frr_checker u_frr_checker (.*);

// *** src/frr_reference_readback_regs.sv ***
// Read-only bank of fixed-point control values of the motor controller
// Assumes the control algorithm updates values on ref_clk_i; software uses the plain port
//
// Overview of operation
// - Report applied q-axis voltage, 27 fraction bits
// - Report rotor-alignment current reference, 27 fraction bits
// - Report open-loop handover speed reference
// - Report open-loop current reference, 27 fraction bits
// - Report closed-loop speed-loop reference value
// - Report flux-axis current reference, 27 fraction bits
// - Read-only, bits 31..0, zero after reset
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "frr_defines.svh"

module frr_reference_readback_regs #(
	parameter int ADDR_W = `FRR_ADDR_W,
	parameter int DATA_W = `FRR_DATA_W
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Software register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	output logic wr_dropped_o,
	// Control algorithm update port
	input wire logic upd_valid_i,
	input wire logic [2:0] upd_slot_i,
	input wire logic [DATA_W-1:0] upd_data_i
);

	// --------------------------------------------------------------
	// Parameter check
	// --------------------------------------------------------------
	if (ADDR_W != `FRR_ADDR_W || DATA_W != `FRR_DATA_W) begin : g_bad_width
		$error("frr_reference_readback_regs: widths must be 12 and 32");
	end

	// --------------------------------------------------------------
	// Address decode
	// --------------------------------------------------------------
	// Returns hit flag in bit 3 and slot in bits 2..0
	function automatic logic [3:0] decode_addr(input logic [ADDR_W-1:0] a);
		logic [3:0] r;
		r = 4'h0;
		case (a)
			`FRR_OFS_APPLIED_Q_VOLTAGE: begin
				r = {1'b1, frr_pkg::FRR_SLOT_APPLIED_Q_VOLTAGE};
			end
			`FRR_OFS_ALIGN_CURRENT_REFERENCE: begin
				r = {1'b1, frr_pkg::FRR_SLOT_ALIGN_CURRENT_REFERENCE};
			end
			`FRR_OFS_OPEN_LOOP_SPEED_REFERENCE: begin
				r = {1'b1, frr_pkg::FRR_SLOT_OPEN_LOOP_SPEED_REFERENCE};
			end
			`FRR_OFS_OPEN_LOOP_CURRENT_REFERENCE: begin
				r = {1'b1, frr_pkg::FRR_SLOT_OPEN_LOOP_CURRENT_REFERENCE};
			end
			`FRR_OFS_CLOSED_LOOP_SPEED_REFERENCE: begin
				r = {1'b1, frr_pkg::FRR_SLOT_CLOSED_LOOP_SPEED_REFERENCE};
			end
			`FRR_OFS_FLUX_CURRENT_REFERENCE: begin
				r = {1'b1, frr_pkg::FRR_SLOT_FLUX_CURRENT_REFERENCE};
			end
			default: begin
				r = 4'h0;
			end
		endcase
		return r;
	endfunction : decode_addr

	// --------------------------------------------------------------
	// Offset table
	// --------------------------------------------------------------
	// Printed offset of each storage slot, indexed by slot number
	function automatic logic [ADDR_W-1:0] slot_offset(input int idx);
		logic [ADDR_W-1:0] o;
		o = ADDR_W'(`FRR_OFS_APPLIED_Q_VOLTAGE);
		case (idx)
			0: begin
				o = ADDR_W'(`FRR_OFS_APPLIED_Q_VOLTAGE);
			end
			1: begin
				o = ADDR_W'(`FRR_OFS_ALIGN_CURRENT_REFERENCE);
			end
			2: begin
				o = ADDR_W'(`FRR_OFS_OPEN_LOOP_SPEED_REFERENCE);
			end
			3: begin
				o = ADDR_W'(`FRR_OFS_OPEN_LOOP_CURRENT_REFERENCE);
			end
			4: begin
				o = ADDR_W'(`FRR_OFS_CLOSED_LOOP_SPEED_REFERENCE);
			end
			5: begin
				o = ADDR_W'(`FRR_OFS_FLUX_CURRENT_REFERENCE);
			end
			default: begin
				o = ADDR_W'(`FRR_OFS_APPLIED_Q_VOLTAGE);
			end
		endcase
		return o;
	endfunction : slot_offset

	// --------------------------------------------------------------
	// One-hot encoding
	// --------------------------------------------------------------
	// Slot number of a one-hot select vector, zero when no bit is set
	function automatic logic [2:0] onehot_to_slot(input logic [`FRR_NUM_REGS-1:0] sel);
		logic [2:0] s;
		s = 3'h0;
		case (sel)
			6'h01: begin
				s = 3'h0;
			end
			6'h02: begin
				s = 3'h1;
			end
			6'h04: begin
				s = 3'h2;
			end
			6'h08: begin
				s = 3'h3;
			end
			6'h10: begin
				s = 3'h4;
			end
			6'h20: begin
				s = 3'h5;
			end
			default: begin
				s = 3'h0;
			end
		endcase
		return s;
	endfunction : onehot_to_slot

	// --------------------------------------------------------------
	// Offset table check
	// --------------------------------------------------------------
	genvar gi, gj;
	for (gi = 0; gi < `FRR_NUM_REGS; gi++) begin : g_ofs_i
		if (decode_addr(slot_offset(gi)) != {1'b1, 3'(gi)}) begin : g_mismatch
			$error("frr_reference_readback_regs: offset table and decoder disagree");
		end
		for (gj = gi + 1; gj < `FRR_NUM_REGS; gj++) begin : g_ofs_j
			if (slot_offset(gi) == slot_offset(gj)) begin : g_dup
				$error("frr_reference_readback_regs: two slots share an offset");
			end
		end
	end

	// --------------------------------------------------------------
	// Per-slot selects
	// --------------------------------------------------------------
	wire logic [`FRR_NUM_REGS-1:0] addr_match;
	wire logic [`FRR_NUM_REGS-1:0] upd_sel;

	for (gi = 0; gi < `FRR_NUM_REGS; gi++) begin : g_sel
		assign addr_match[gi] = (addr_i == slot_offset(gi));
		assign upd_sel[gi] = upd_valid_i && (upd_slot_i == 3'(gi));
	end

	wire logic [3:0] wr_dec = decode_addr(addr_i);
	wire logic rd_hit = |addr_match;
	wire logic [2:0] rd_slot = onehot_to_slot(addr_match);
	wire logic upd_ok = |upd_sel;
	wire logic [2:0] upd_slot = onehot_to_slot(upd_sel);
	wire logic next_wr_dropped = wr_i && wr_dec[3];

	// --------------------------------------------------------------
	// Value storage
	// --------------------------------------------------------------
	// Software data never reach the store; only the algorithm writes it
	frr_value_store #(
		.DEPTH(`FRR_NUM_REGS),
		.WIDTH(DATA_W)
	) u_store (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.wr_en_i(upd_ok),
		.wr_slot_i(upd_slot),
		.wr_data_i(upd_data_i),
		.rd_en_i(1'b1),
		.rd_hit_i(rd_i && rd_hit),
		.rd_slot_i(rd_slot),
		.rd_data_o(rdata_o)
	);

	// --------------------------------------------------------------
	// Write drop indication
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			wr_dropped_o <= 1'b0;
		end else begin
			wr_dropped_o <= next_wr_dropped;
		end
	end

	wire logic [DATA_W-1:0] unused_wdata = wdata_i;

endmodule : frr_reference_readback_regs

// *** src/frr_value_store.sv ***
// Small storage of the bank values with registered read data
// Assumes one clock, synchronous active-low reset, single writer
`timescale 1ns/1ps
`include "frr_defines.svh"

module frr_value_store #(
	parameter int DEPTH = `FRR_NUM_REGS,
	parameter int WIDTH = `FRR_DATA_W
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic wr_en_i,
	input wire logic [2:0] wr_slot_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic rd_hit_i,
	input wire logic [2:0] rd_slot_i,
	output logic [WIDTH-1:0] rd_data_o
);

	// --------------------------------------------------------------
	// Parameter check
	// --------------------------------------------------------------
	if (DEPTH < 1 || DEPTH > 8) begin : g_bad_depth
		$error("frr_value_store: DEPTH must be 1 to 8");
	end

	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];
	wire logic [WIDTH-1:0] next_rd_data;

	genvar gi;
	for (gi = 0; gi < DEPTH; gi++) begin : g_word
		always_ff @(posedge ref_clk_i) begin
			if (!resetn_i) begin
				mem[gi] <= `FRR_RESET_VALUE;
			end else if (wr_en_i && wr_slot_i == 3'(gi)) begin
				mem[gi] <= wr_data_i;
			end
		end
	end

	// --------------------------------------------------------------
	// Read port
	// --------------------------------------------------------------
	assign next_rd_data = (rd_hit_i && int'(rd_slot_i) < DEPTH) ? mem[rd_slot_i]
		: `FRR_UNMAPPED_VALUE;

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rd_data_o <= `FRR_RESET_VALUE;
		end else if (rd_en_i) begin
			rd_data_o <= next_rd_data;
		end
	end

endmodule : frr_value_store
